// ### pport.sv
// Parallel port host register file with enhanced read cycle and shared FIFO.
// =============================================================================
// Summary of operation
// [R1] Stretch host read while wait input low.
// [R2] Software sets direction bit before reads.
// [R3] Assert data or address strobe on read.
// [R4] Wait states until release or time-out.
// [R5] Peripheral drives data before releasing wait.
// [R6] On release: final sync, strobe deasserted.
// [R7] Peripheral releases bus after strobe ends.
// [R8] Write-select low for writes, high otherwise; the code drives it low whenever idle with the direction bit clear.
// [R9] Interrupt input passed through, active high.
// [R10] Wait high acknowledges, low means not ready.
// [R11] Separate active-low data and address strobes.
// [R12] Active-low peripheral reset output provided.
// [R13] Only write-select overridable by control register.
// [R14] Port word fixed at eight bits.
// [R15] Data, status, control reachable in all modes.
// [R16] All FIFOs share one 16-byte store.
// [R17] Config B reports selected interrupt, DMA.
// [R18] Optional run-length compression up to 64:1.
// [R19] Watchdog flags cycles over ten microseconds.
// [R20] Time-out aborts cycle, sets status bit 0.
// [R21] Wait input passes two-stage synchronizer.
// =============================================================================
`timescale 1ns/1ps

module pport #(
    parameter int FIFO_DEPTH = pport_pkg::FIFO_BYTES,
    parameter int TIMEOUT_CYCLES = pport_pkg::EPP_TIMEOUT_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic io_read,
    input wire logic io_write,
    input wire logic [pport_pkg::ADDR_BITS-1:0] io_addr,
    input wire logic [pport_pkg::PORT_WORD_BITS-1:0] io_wdata,
    output logic [pport_pkg::PORT_WORD_BITS-1:0] io_rdata,
    output logic io_done,
    output logic io_wait,
    input wire logic [pport_pkg::PORT_WORD_BITS-1:0] parallel_bus_in,
    output logic [pport_pkg::PORT_WORD_BITS-1:0] parallel_bus_out,
    output logic parallel_bus_oe,
    input wire logic peripheral_wait_n,
    input wire logic peripheral_interrupt,
    input wire logic line_busy,
    input wire logic line_ack_n,
    input wire logic line_perror,
    input wire logic line_select,
    input wire logic line_fault_n,
    input wire logic [2:0] cfg_irq_sel,
    input wire logic [2:0] cfg_dma_sel,
    output logic write_select_n,
    output logic data_strobe_n,
    output logic address_strobe_n,
    output logic peripheral_reset_n,
    output logic peripheral_irq
);
    import pport_pkg::*;

    localparam int PTR_BITS = $clog2(FIFO_DEPTH);
    localparam logic [TIMER_BITS-1:0] TIMER_LAST = TIMER_BITS'(TIMEOUT_CYCLES - 1);
    localparam logic [PTR_BITS:0] FIFO_FULL_COUNT = (PTR_BITS+1)'(FIFO_DEPTH);

    if (FIFO_DEPTH < 2 || (1 << PTR_BITS) != FIFO_DEPTH) begin : g_bad_depth
        $error("FIFO_DEPTH must be a power of two of at least 2");
    end
    if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (1 << TIMER_BITS)) begin : g_bad_timeout
        $error("TIMEOUT_CYCLES must fit the watchdog counter");
    end

    // =========================================================================
    // State
    // =========================================================================
    cycle_state_t state_q;
    logic [TIMER_BITS-1:0] timer_q;
    logic wait_low_seen_q;
    logic wait_meta_q;
    logic wait_sync_q;
    logic timeout_q;
    logic [7:0] ctl_q;
    logic [7:0] data_q;
    logic [5:0] ecr_q;
    logic compress_q;
    logic [7:0] fifo_mem_q [FIFO_DEPTH];
    logic fifo_tag_q [FIFO_DEPTH];
    logic [RUN_BITS-1:0] fifo_run_q [FIFO_DEPTH];
    logic [PTR_BITS-1:0] wr_ptr_q;
    logic [PTR_BITS-1:0] rd_ptr_q;
    logic [PTR_BITS:0] count_q;
    logic pend_valid_q;
    logic [7:0] pend_byte_q;
    logic [RUN_BITS-1:0] run_q;

    logic [2:0] mode;
    logic fifo_full;
    logic fifo_empty;
    logic epp_start;
    logic simple_req;
    logic pop_en;
    logic push_en;
    logic [7:0] push_data;
    logic push_tag;
    logic [RUN_BITS-1:0] push_run;
    logic [7:0] read_mux;
    logic data_fifo_wr;
    logic wait_release;

    assign mode = ecr_q[5:3];
    assign wait_release = wait_sync_q && wait_low_seen_q;
    assign fifo_empty = (count_q == '0);
    assign fifo_full = (count_q == FIFO_FULL_COUNT);
    assign epp_start = io_read && state_q == ST_IDLE && mode == MODE_ENHANCED &&
                       (io_addr == OFS_EPP_ADDRESS || io_addr == OFS_EPP_DATA);
    assign simple_req = (io_read || io_write) && state_q == ST_IDLE && !epp_start;
    assign data_fifo_wr = simple_req && io_write && io_addr == OFS_FIFO_PORT &&
                          mode == MODE_EXTENDED && compress_q;

    // =========================================================================
    // Wait input synchroniser
    // =========================================================================
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wait_meta_q <= 1'b1;
            wait_sync_q <= 1'b1;
        end else begin
            wait_meta_q <= peripheral_wait_n; // [R21]
            wait_sync_q <= wait_meta_q; // [R21]
        end
    end

    // The synchroniser still shows the last release for two edges after a cycle ends, so a
    // release only counts once the wait line has been seen low in the current cycle.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wait_low_seen_q <= 1'b0;
        end else if (epp_start) begin
            wait_low_seen_q <= 1'b0;
        end else if (state_q == ST_ACTIVE && !wait_sync_q) begin
            wait_low_seen_q <= 1'b1; // [R1]
        end
    end

    // =========================================================================
    // Enhanced read cycle and watchdog
    // =========================================================================
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            timer_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    timer_q <= '0;
                    if (epp_start) begin
                        state_q <= ST_ACTIVE; // [R3]
                    end
                end
                ST_ACTIVE: begin
                    timer_q <= timer_q + 1'b1; // [R19]
                    if (wait_release || timer_q == TIMER_LAST) begin
                        state_q <= ST_REPLY; // [R6] [R20]
                    end
                end
                ST_REPLY: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // The strobe drops in the same edge that returns the final sync, so the
    // peripheral sees its bus released before the host can start a new cycle.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            data_strobe_n <= 1'b1;
            address_strobe_n <= 1'b1;
            io_wait <= 1'b0;
        end else begin
            if (epp_start) begin
                data_strobe_n <= (io_addr == OFS_EPP_ADDRESS); // [R3] [R11]
                address_strobe_n <= (io_addr != OFS_EPP_ADDRESS); // [R3] [R11]
                io_wait <= 1'b1; // [R1]
            end else if (state_q == ST_ACTIVE && (wait_release || timer_q == TIMER_LAST)) begin
                data_strobe_n <= 1'b1; // [R6]
                address_strobe_n <= 1'b1; // [R6]
                io_wait <= 1'b0; // [R4]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            io_done <= 1'b0;
            io_rdata <= 8'h00;
        end else begin
            io_done <= 1'b0;
            if (state_q == ST_ACTIVE && wait_release) begin
                io_done <= 1'b1; // [R6]
                io_rdata <= parallel_bus_in; // [R5] [R10]
            end else if (state_q == ST_ACTIVE && timer_q == TIMER_LAST) begin
                io_done <= 1'b1; // [R20]
                io_rdata <= TIMEOUT_READ_VALUE; // [R20]
            end else if (simple_req) begin
                io_done <= 1'b1;
                io_rdata <= io_read ? read_mux : 8'h00;
            end
        end
    end

    // =========================================================================
    // Pin drivers
    // =========================================================================
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            write_select_n <= 1'b1;
            parallel_bus_oe <= 1'b0;
            parallel_bus_out <= 8'h00;
            peripheral_reset_n <= 1'b0;
            peripheral_irq <= 1'b0;
        end else begin
            if (ctl_q[CTL_STROBE_BIT]) begin
                write_select_n <= 1'b0; // [R13]
            end else begin
                write_select_n <= (state_q != ST_IDLE) || epp_start || ctl_q[CTL_DIR_BIT]; // [R8]
            end
            // Drive only in forward direction and never while a read owns the bus.
            parallel_bus_oe <= !ctl_q[CTL_DIR_BIT] && state_q == ST_IDLE && !epp_start; // [R2] [R7]
            parallel_bus_out <= data_q;
            peripheral_reset_n <= ctl_q[CTL_INIT_BIT]; // [R12]
            peripheral_irq <= peripheral_interrupt; // [R9]
        end
    end

    // =========================================================================
    // Register file
    // =========================================================================
    always_comb begin
        read_mux = 8'h00;
        case (io_addr)
            OFS_PORT_DATA: read_mux = ctl_q[CTL_DIR_BIT] ? parallel_bus_in : data_q; // [R15]
            OFS_LINE_STATUS: read_mux = {!line_busy, line_ack_n, line_perror, line_select,
                                         line_fault_n, 2'b00, timeout_q}; // [R15]
            OFS_LINE_CONTROL: read_mux = ctl_q & LINE_CONTROL_MASK; // [R15]
            OFS_FIFO_PORT: begin
                if (mode == MODE_CONFIG) begin
                    read_mux = CONFIG_A_VALUE;
                end else if (!fifo_empty) begin
                    read_mux = fifo_mem_q[rd_ptr_q]; // [R16]
                end
            end
            OFS_CONFIG_B: read_mux = {compress_q, peripheral_interrupt, cfg_irq_sel,
                                      cfg_dma_sel}; // [R17]
            OFS_EXT_CONTROL: read_mux = {ecr_q, fifo_full, fifo_empty};
            default: read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctl_q <= LINE_CONTROL_RESET;
            data_q <= 8'h00;
            ecr_q <= EXT_CONTROL_RESET;
            compress_q <= 1'b0;
        end else if (simple_req && io_write) begin
            case (io_addr)
                OFS_PORT_DATA: begin
                    if (mode != MODE_EXTENDED) begin
                        data_q <= io_wdata;
                    end
                end
                OFS_LINE_CONTROL: ctl_q <= io_wdata & LINE_CONTROL_MASK; // [R15]
                OFS_CONFIG_B: compress_q <= io_wdata[CFGB_COMPRESS_BIT]; // [R18]
                OFS_EXT_CONTROL: ecr_q <= io_wdata[7:2];
                default: begin
                end
            endcase
        end
    end

    // A new time-out wins over a software clear in the same cycle.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            timeout_q <= 1'b0;
        end else if (state_q == ST_ACTIVE && !wait_release && timer_q == TIMER_LAST) begin
            timeout_q <= 1'b1; // [R20]
        end else if (simple_req && io_write && io_addr == OFS_LINE_STATUS &&
                     io_wdata[STS_TIMEOUT_BIT]) begin
            timeout_q <= 1'b0;
        end
    end

    // =========================================================================
    // Shared FIFO with run-length compressor
    // =========================================================================
    // One byte is held back while a run builds up, so the host sees it in the FIFO only after a different
    // byte arrives, the same byte arrives with the run count at RUN_MAX, or the mode register is written.
    always_comb begin
        push_en = 1'b0;
        push_data = io_wdata;
        push_tag = 1'b0;
        push_run = '0;
        if (data_fifo_wr) begin
            if (pend_valid_q && !(io_wdata == pend_byte_q && run_q != RUN_MAX)) begin
                push_en = 1'b1; // [R18]
                push_data = pend_byte_q;
                push_run = run_q;
            end
        end else if (simple_req && io_write && io_addr == OFS_EXT_CONTROL && pend_valid_q) begin
            push_en = 1'b1;
            push_data = pend_byte_q;
            push_run = run_q;
        end else if (simple_req && io_write && io_addr == OFS_PORT_DATA &&
                     mode == MODE_EXTENDED) begin
            push_en = 1'b1; // [R16]
            push_tag = 1'b1;
        end else if (simple_req && io_write && io_addr == OFS_FIFO_PORT &&
                     (mode == MODE_COMPAT_FIFO || mode == MODE_EXTENDED || mode == MODE_TEST)) begin
            push_en = 1'b1; // [R16]
        end
    end

    assign pop_en = simple_req && io_read && io_addr == OFS_FIFO_PORT && !fifo_empty &&
                    (mode == MODE_EXTENDED || mode == MODE_TEST);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pend_valid_q <= 1'b0;
            pend_byte_q <= 8'h00;
            run_q <= '0;
        end else if (data_fifo_wr) begin
            if (pend_valid_q && io_wdata == pend_byte_q && run_q != RUN_MAX) begin
                run_q <= run_q + 1'b1; // [R18]
            end else if (!pend_valid_q || !fifo_full) begin
                pend_valid_q <= 1'b1;
                pend_byte_q <= io_wdata;
                run_q <= '0;
            end
        end else if (push_en && !push_tag && pend_valid_q && !fifo_full &&
                     io_addr == OFS_EXT_CONTROL) begin
            pend_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (push_en && !fifo_full) begin
            fifo_mem_q[wr_ptr_q] <= push_data; // [R14] [R16]
            fifo_tag_q[wr_ptr_q] <= push_tag;
            fifo_run_q[wr_ptr_q] <= push_run;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push_en && !fifo_full) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop_en) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if ((push_en && !fifo_full) && !pop_en) begin
                count_q <= count_q + 1'b1;
            end else if (!(push_en && !fifo_full) && pop_en) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    // =========================================================================
    // Checks
    // =========================================================================
    a_wait_extends: assert property (@(posedge clock) disable iff (sys_rst) // [R1]
        (state_q == ST_ACTIVE && !wait_release && timer_q != TIMER_LAST) |=> !io_done && io_wait)
        else $error("read completed while wait input low");
    a_strobe_start: assert property (@(posedge clock) disable iff (sys_rst) // [R3]
        epp_start |=> (data_strobe_n != address_strobe_n) && !parallel_bus_oe && io_wait)
        else $error("read cycle did not raise exactly one strobe");
    a_release_ends: assert property (@(posedge clock) disable iff (sys_rst) // [R6]
        (state_q == ST_ACTIVE && wait_release) |=> io_done && data_strobe_n && address_strobe_n
        ##1 !io_done)
        else $error("release did not end the read cycle");
    a_sync_delay: assert property (@(posedge clock) disable iff (sys_rst) // [R21]
        !$stable(peripheral_wait_n) |-> ##2 (wait_sync_q == $past(peripheral_wait_n, 2)))
        else $error("wait synchroniser delay wrong");
    a_timeout_abort: assert property (@(posedge clock) disable iff (sys_rst) // [R20]
        (state_q == ST_ACTIVE && !wait_release && timer_q == TIMER_LAST) |=>
        timeout_q && io_done && io_rdata == TIMEOUT_READ_VALUE && data_strobe_n && address_strobe_n)
        else $error("time-out did not abort the cycle");
    a_timer_bound: assert property (@(posedge clock) disable iff (sys_rst) // [R19]
        (state_q == ST_ACTIVE) |-> timer_q <= TIMER_LAST)
        else $error("watchdog counter ran past its limit");
    a_single_strobe: assert property (@(posedge clock) disable iff (sys_rst) // [R11]
        !(!data_strobe_n && !address_strobe_n))
        else $error("both strobes asserted");
    a_read_wsel: assert property (@(posedge clock) disable iff (sys_rst) // [R8]
        (state_q == ST_ACTIVE && !$past(ctl_q[CTL_STROBE_BIT])) |-> write_select_n)
        else $error("write-select low during read");
    a_irq_pass: assert property (@(posedge clock) disable iff (sys_rst) // [R9]
        $rose(peripheral_interrupt) |=> peripheral_irq)
        else $error("interrupt edge not passed through");
    a_reset_out: assert property (@(posedge clock) disable iff (sys_rst) // [R12]
        !ctl_q[CTL_INIT_BIT] |=> !peripheral_reset_n)
        else $error("peripheral reset not asserted");
    a_fifo_bound: assert property (@(posedge clock) disable iff (sys_rst) // [R16]
        (count_q <= FIFO_FULL_COUNT) && (!fifo_full || count_q != '0))
        else $error("shared FIFO count out of range");
    a_run_cap: assert property (@(posedge clock) disable iff (sys_rst) // [R18]
        (data_fifo_wr && pend_valid_q && io_wdata == pend_byte_q && run_q != RUN_MAX)
        |=> run_q == $past(run_q) + 1'b1)
        else $error("run length not counted");

endmodule : pport

// ### pport_peer.sv
// Peripheral model on the cable side of the parallel port.
`timescale 1ns/1ps

module pport_peer (
    input wire logic clock,
    input wire logic data_strobe_n,
    input wire logic address_strobe_n,
    input wire logic stall,
    input wire logic [3:0] lag,
    input wire logic [7:0] value,
    output logic peripheral_wait_n,
    output logic [7:0] bus
);
    logic [3:0] cnt_q;
    initial begin
        cnt_q = 4'h0;
        peripheral_wait_n = 1'b0;
        bus = 8'h5a;
    end
    always @(posedge clock) begin
        if (!data_strobe_n || !address_strobe_n) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == lag) begin
                bus <= value;
            end
            if (cnt_q > lag && !stall) begin
                peripheral_wait_n <= 1'b1;
            end
        end else begin
            // A released bus toggles so that stale data can never match.
            cnt_q <= 4'h0;
            bus <= ~bus;
            peripheral_wait_n <= 1'b0;
        end
    end
endmodule : pport_peer

// ### pport_pkg.sv
// Shared constants for the parallel port block.
package pport_pkg;

    // =========================================================================
    // Widths and timing
    // =========================================================================
    localparam int PORT_WORD_BITS = 8;
    localparam int FIFO_BYTES = 16;
    localparam int CLOCK_MHZ = 250;
    localparam int EPP_TIMEOUT_US = 10;
    localparam int EPP_TIMEOUT_CYCLES = EPP_TIMEOUT_US * CLOCK_MHZ;
    localparam int TIMER_BITS = 12;
    localparam int RUN_BITS = 6;
    localparam logic [RUN_BITS-1:0] RUN_MAX = 6'h3f;

    // =========================================================================
    // Register offsets from the port base
    // =========================================================================
    localparam int ADDR_BITS = 11;
    localparam logic [10:0] OFS_PORT_DATA = 11'h000;
    localparam logic [10:0] OFS_LINE_STATUS = 11'h001;
    localparam logic [10:0] OFS_LINE_CONTROL = 11'h002;
    localparam logic [10:0] OFS_EPP_ADDRESS = 11'h003;
    localparam logic [10:0] OFS_EPP_DATA = 11'h004;
    localparam logic [10:0] OFS_FIFO_PORT = 11'h400;
    localparam logic [10:0] OFS_CONFIG_B = 11'h401;
    localparam logic [10:0] OFS_EXT_CONTROL = 11'h402;

    // =========================================================================
    // Field positions and reset values
    // =========================================================================
    localparam int STS_TIMEOUT_BIT = 0;
    localparam int CTL_STROBE_BIT = 0;
    localparam int CTL_INIT_BIT = 2;
    localparam int CTL_DIR_BIT = 5;
    localparam int CFGB_COMPRESS_BIT = 7;
    localparam logic [7:0] LINE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] LINE_CONTROL_MASK = 8'h3f;
    localparam logic [5:0] EXT_CONTROL_RESET = 6'h01;
    localparam logic [7:0] CONFIG_A_VALUE = 8'h10;
    localparam logic [7:0] TIMEOUT_READ_VALUE = 8'hff;

    // =========================================================================
    // Port modes held in the upper extended control bits
    // =========================================================================
    localparam logic [2:0] MODE_STANDARD = 3'h0;
    localparam logic [2:0] MODE_COMPAT_FIFO = 3'h2;
    localparam logic [2:0] MODE_EXTENDED = 3'h3;
    localparam logic [2:0] MODE_ENHANCED = 3'h4;
    localparam logic [2:0] MODE_TEST = 3'h6;
    localparam logic [2:0] MODE_CONFIG = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_REPLY
    } cycle_state_t;

endpackage : pport_pkg

// ### pport_tb.sv
// Self-checking testbench for the parallel port block.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module pport_tb;
    import pport_pkg::*;
    localparam int TMO = 20;
    logic clock = 1'b0, sys_rst = 1'b1, io_read = 1'b0, io_write = 1'b0;
    logic [10:0] io_addr = 11'h000;
    logic [7:0] io_wdata = 8'h00, io_rdata, parallel_bus_out, pbus, value = 8'h00, q;
    logic io_done, io_wait, parallel_bus_oe, peripheral_wait_n, peripheral_interrupt = 1'b0;
    logic line_busy = 1'b0, line_ack_n = 1'b1, line_perror = 1'b0, line_select = 1'b0;
    logic line_fault_n = 1'b1, write_select_n, data_strobe_n, address_strobe_n;
    logic [2:0] cfg_irq_sel = 3'h0, cfg_dma_sel = 3'h0;
    logic peripheral_reset_n, peripheral_irq, stall = 1'b0, ds_seen, as_seen, bad;
    logic [3:0] lag = 4'h0;
    logic [31:0] seed = 32'hdaf07d99, r;
    int error_cnt = 0, checked = 0, n;
    logic [7:0] model[$];
    wire [7:0] parallel_bus_in = parallel_bus_oe ? parallel_bus_out : pbus;

    always #2 clock = ~clock;

    pport #(.TIMEOUT_CYCLES(TMO)) pport_i (.clock(clock), .sys_rst(sys_rst),
        .io_read(io_read), .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_done(io_done), .io_wait(io_wait),
        .parallel_bus_in(parallel_bus_in), .parallel_bus_out(parallel_bus_out),
        .parallel_bus_oe(parallel_bus_oe), .peripheral_wait_n(peripheral_wait_n),
        .peripheral_interrupt(peripheral_interrupt), .line_busy(line_busy),
        .line_ack_n(line_ack_n), .line_perror(line_perror), .line_select(line_select),
        .line_fault_n(line_fault_n), .cfg_irq_sel(cfg_irq_sel), .cfg_dma_sel(cfg_dma_sel),
        .write_select_n(write_select_n), .data_strobe_n(data_strobe_n),
        .address_strobe_n(address_strobe_n), .peripheral_reset_n(peripheral_reset_n),
        .peripheral_irq(peripheral_irq));

    pport_peer pport_peer_i (.clock(clock), .data_strobe_n(data_strobe_n),
        .address_strobe_n(address_strobe_n), .stall(stall), .lag(lag), .value(value),
        .peripheral_wait_n(peripheral_wait_n), .bus(pbus));

    // Strobe phase must show a released bus, read select and a stretched host cycle.
    always @(posedge clock) begin
        if (!data_strobe_n) ds_seen <= 1'b1;
        if (!address_strobe_n) as_seen <= 1'b1;
        if ((!data_strobe_n || !address_strobe_n) && (write_select_n !== 1'b1
            || parallel_bus_oe !== 1'b0 || io_wait !== 1'b1)) bad <= 1'b1;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic acc(input logic wr, input logic [10:0] a, input logic [7:0] d);
        @(posedge clock);
        io_write <= wr;
        io_read <= !wr;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clock);
        io_write <= 1'b0;
        io_read <= 1'b0;
        n = 0;
        #1;
        while (io_done !== 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        q = io_rdata;
        if (n == 100) error_cnt++;
    endtask : acc

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1 `CHK(peripheral_reset_n, 1'b0)
        acc(1'b1, OFS_LINE_CONTROL, 8'h24);
        @(posedge clock);
        #1 `CHK(peripheral_reset_n, 1'b1)
        acc(1'b0, OFS_LINE_CONTROL, 8'h00);
        `CHK(q, 8'h24)
        for (int i = 0; i < 4; i++) begin
            r = xs();
            {line_busy, line_ack_n, line_perror, line_select, line_fault_n} <= r[4:0];
            peripheral_interrupt <= r[5];
            cfg_irq_sel <= r[8:6];
            cfg_dma_sel <= r[11:9];
            acc(1'b0, OFS_LINE_STATUS, 8'h00);
            `CHK(q, {~r[4], r[3:0], 3'b000})
            `CHK(peripheral_irq, r[5])
            acc(1'b0, OFS_CONFIG_B, 8'h00);
            `CHK(q[5:0], {r[8:6], r[11:9]})
            `CHK(q[6], r[5])
        end
        $display("test status and config done");
        acc(1'b1, OFS_EXT_CONTROL, 8'h80);
        for (int i = 0; i < 6; i++) begin
            r = xs();
            value <= r[7:0];
            lag <= {1'b0, r[10:8]};
            ds_seen = 1'b0;
            as_seen = 1'b0;
            bad = 1'b0;
            acc(1'b0, i[0] ? OFS_EPP_ADDRESS : OFS_EPP_DATA, 8'h00);
            `CHK(q, r[7:0])
            `CHK({ds_seen, as_seen}, i[0] ? 2'b01 : 2'b10)
            `CHK(bad, 1'b0)
            `CHK({data_strobe_n, address_strobe_n, io_wait}, 3'b110)
        end
        $display("test enhanced reads done");
        stall <= 1'b1;
        acc(1'b0, OFS_EPP_DATA, 8'h00);
        `CHK(q, TIMEOUT_READ_VALUE)
        `CHK(n > TMO - 2 && n < TMO + 2, 1'b1)
        stall <= 1'b0;
        acc(1'b0, OFS_LINE_STATUS, 8'h00);
        `CHK(q[STS_TIMEOUT_BIT], 1'b1)
        acc(1'b1, OFS_LINE_STATUS, 8'h01);
        acc(1'b0, OFS_LINE_STATUS, 8'h00);
        `CHK(q[STS_TIMEOUT_BIT], 1'b0)
        $display("test time-out done");
        acc(1'b1, OFS_EXT_CONTROL, 8'hc0);
        for (int i = 0; i < 17; i++) begin
            r = xs();
            if (model.size() < FIFO_BYTES) model.push_back(r[7:0]);
            acc(1'b1, OFS_FIFO_PORT, r[7:0]);
        end
        acc(1'b0, OFS_EXT_CONTROL, 8'h00);
        `CHK(q[1:0], 2'b10)
        while (model.size() > 0) begin
            r[7:0] = model.pop_front();
            acc(1'b0, OFS_FIFO_PORT, 8'h00);
            `CHK(q, r[7:0])
        end
        acc(1'b0, OFS_EXT_CONTROL, 8'h00);
        `CHK(q[1:0], 2'b01)
        $display("test shared fifo done");
        acc(1'b1, OFS_EXT_CONTROL, 8'h60);
        acc(1'b1, OFS_CONFIG_B, 8'h80);
        for (int i = 0; i < 5; i++) acc(1'b1, OFS_FIFO_PORT, i < 3 ? 8'h3c : 8'hc3);
        acc(1'b1, OFS_EXT_CONTROL, 8'h60);
        acc(1'b0, OFS_EXT_CONTROL, 8'h00);
        `CHK(q[1:0], 2'b00)
        acc(1'b0, OFS_FIFO_PORT, 8'h00);
        `CHK(q, 8'h3c)
        acc(1'b0, OFS_FIFO_PORT, 8'h00);
        `CHK(q, 8'hc3)
        acc(1'b1, OFS_EXT_CONTROL, 8'he0);
        acc(1'b0, OFS_FIFO_PORT, 8'h00);
        `CHK(q, CONFIG_A_VALUE)
        $display("test compression done");
        give_verdict();
    end
endmodule : pport_tb
